// >>> src/breakpoint_watchpoint_unit.sv
// What this block does
// [RULE1] PC equals breakpoint address raises debug interrupt
// [RULE2] Four independent instruction breakpoints with registers
// [RULE3] Per-core enable byte gates every comparator
// [RULE4] Invert bit fires breakpoint on PC mismatch
// [RULE5] Bit zero enables comparator; reset off
// [RULE6] Four data watchpoints with two bounds
// [RULE7] Normal range match includes both bounds
// [RULE8] Inverted range match excludes both bounds
// [RULE9] Stores always watched; loads need enable bit
// [RULE10] Four resource watchpoints: mask and value
// [RULE11] Masked id equal to value triggers
// [RULE12] Inverted: masked id unequal triggers
// [RULE13] Record cause code 3, 4 or 5
// [RULE14] Record lowest-numbered triggering unit number
// [RULE15] Capture address or resource id on hit
//
// The implementer's own choice: strobed register access.
module breakpoint_watchpoint_unit
    import bp_watch_pkg::*;
(
    input  wire logic         clock,
    input  wire logic         reset,
    input  wire logic [7:0]   reg_addr,
    input  wire logic [31:0]  reg_wdata,
    input  wire logic         reg_write,
    input  wire logic         reg_read,
    output logic      [31:0]  reg_rdata,
    input  wire fetch_req_t   fetch_req,
    input  wire mem_req_t     mem_req,
    input  wire res_req_t     res_req,
    output debug_event_t      debug_event,
    output logic              irq
);

    ////////////////////////////////////////////////////////////////////////////
    // Register storage

    logic [31:0] ib_addr_q   [unit_count];
    logic [31:0] ib_ctrl_q   [unit_count];
    logic [31:0] dw_first_q  [unit_count];
    logic [31:0] dw_second_q [unit_count];
    logic [31:0] dw_ctrl_q   [unit_count];
    logic [31:0] rw_mask_q   [unit_count];
    logic [31:0] rw_value_q  [unit_count];
    logic [31:0] rw_ctrl_q   [unit_count];
    logic [2:0]  cause_q;
    logic [1:0]  number_q;
    logic [7:0]  core_q;
    logic [31:0] data_q;
    logic [2:0]  status_q;
    logic [2:0]  mask_q;
    logic [31:0] rdata_q;
    debug_event_t event_q;

    logic [unit_count-1:0] ib_hit;
    logic [unit_count-1:0] dw_hit;
    logic [unit_count-1:0] rw_hit;

    ////////////////////////////////////////////////////////////////////////////
    // Comparators

    for (genvar i = 0; i < unit_count; i++) begin : g_cmp
        wire         ib_en     = ib_ctrl_q[i][ctrl_enable_bit];                          // [RULE5]
        wire         ib_core   = ib_ctrl_q[i][ctrl_core_lsb + 32'(fetch_req.core)];      // [RULE3]
        wire         pc_equal  = fetch_req.program_counter == ib_addr_q[i];
        wire         pc_match  = pc_equal ^ ib_ctrl_q[i][ctrl_invert_bit];               // [RULE4]
        assign ib_hit[i] = fetch_req.valid & ib_en & ib_core & pc_match;                // [RULE1]

        wire         dw_en     = dw_ctrl_q[i][ctrl_enable_bit];                          // [RULE5]
        wire         dw_core   = dw_ctrl_q[i][ctrl_core_lsb + 32'(mem_req.core)];        // [RULE3]
        wire         dw_kind   = mem_req.store | dw_ctrl_q[i][ctrl_load_bit];            // [RULE9]
        wire         in_range  = (mem_req.addr >= dw_first_q[i]) &&
                                 (mem_req.addr <= dw_second_q[i]);                       // [RULE7]
        // Outside test is the exact complement, so both bounds miss
        wire         dw_match  = dw_ctrl_q[i][ctrl_invert_bit] ? !in_range : in_range;   // [RULE8]
        assign dw_hit[i] = mem_req.valid & dw_en & dw_core & dw_kind & dw_match;

        wire         rw_en     = rw_ctrl_q[i][ctrl_enable_bit];                          // [RULE5]
        wire         rw_core   = rw_ctrl_q[i][ctrl_core_lsb + 32'(res_req.core)];        // [RULE3]
        wire         rw_equal  = (res_req.res_id & rw_mask_q[i]) == rw_value_q[i];       // [RULE11]
        wire         rw_match  = rw_equal ^ rw_ctrl_q[i][ctrl_invert_bit];               // [RULE12]
        assign rw_hit[i] = res_req.valid & rw_en & rw_core & rw_match;
    end

    function automatic logic [1:0] lowest(input logic [unit_count-1:0] v);
        logic [1:0] n;
        n = 2'h0;
        for (int k = unit_count - 1; k >= 0; k--) begin
            if (v[k]) begin
                n = 2'(k);
            end
        end
        return n;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Event selection: instruction before data before resource

    wire         any_ib  = |ib_hit;
    wire         any_dw  = |dw_hit;
    wire         any_rw  = |rw_hit;
    wire         any_hit = any_ib | any_dw | any_rw;

    wire [2:0]   hit_cause  = any_ib ? cause_instr :
                              any_dw ? cause_data  :
                              any_rw ? cause_resource : cause_none;                      // [RULE13]
    wire [1:0]   hit_number = any_ib ? lowest(ib_hit) :
                              any_dw ? lowest(dw_hit) : lowest(rw_hit);                  // [RULE14]
    wire [2:0]   hit_core   = any_ib ? fetch_req.core :
                              any_dw ? mem_req.core : res_req.core;
    // Instruction hits carry no data word, so the old one is kept
    wire         data_load  = !any_ib & (any_dw | any_rw);
    wire [31:0]  hit_data   = any_dw ? mem_req.addr : res_req.res_id;                    // [RULE15]
    wire [2:0]   hit_flags  = {any_rw, any_dw, any_ib};

    ////////////////////////////////////////////////////////////////////////////
    // Register decode

    wire [1:0]   idx       = reg_addr[1:0];
    wire [5:0]   grp       = reg_addr[7:2];
    wire         sel_ib_a  = grp == instr_break_address_base[7:2];
    wire         sel_ib_c  = grp == instr_break_control_base[7:2];
    wire         sel_dw_1  = grp == data_watch_first_bound_base[7:2];
    wire         sel_dw_2  = grp == data_watch_second_bound_base[7:2];
    wire         sel_dw_c  = grp == data_watch_control_base[7:2];
    wire         sel_rw_m  = grp == resource_watch_mask_base[7:2];
    wire         sel_rw_v  = grp == resource_watch_value_base[7:2];
    wire         sel_rw_c  = grp == resource_watch_control_base[7:2];
    wire         sel_cause = reg_addr == debug_cause_reg;
    wire         sel_data  = reg_addr == debug_data_reg;
    wire         sel_stat  = reg_addr == irq_status_reg;
    wire         sel_mask  = reg_addr == irq_mask_reg;

    wire [31:0]  cause_word = {14'h0, number_q, core_q, 5'h0, cause_q};

    wire [31:0]  read_mux =
        sel_ib_a  ? ib_addr_q[idx]   :
        sel_ib_c  ? ib_ctrl_q[idx]   :
        sel_dw_1  ? dw_first_q[idx]  :
        sel_dw_2  ? dw_second_q[idx] :
        sel_dw_c  ? dw_ctrl_q[idx]   :
        sel_rw_m  ? rw_mask_q[idx]   :
        sel_rw_v  ? rw_value_q[idx]  :
        sel_rw_c  ? rw_ctrl_q[idx]   :
        sel_cause ? cause_word       :
        sel_data  ? data_q           :
        sel_stat  ? {29'h0, status_q} :
        sel_mask  ? {29'h0, mask_q}   : 32'h0000_0000;

    // Hardware set wins over a same-cycle write-one clear
    wire [2:0]   status_clr = (reg_write && sel_stat) ? reg_wdata[2:0] : 3'h0;
    wire [2:0]   status_d   = (status_q & ~status_clr) | hit_flags;

    ////////////////////////////////////////////////////////////////////////////
    // Configuration registers

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            for (int k = 0; k < unit_count; k++) begin
                ib_addr_q[k]   <= reg_reset;
                ib_ctrl_q[k]   <= reg_reset;                                             // [RULE5]
                dw_first_q[k]  <= reg_reset;
                dw_second_q[k] <= reg_reset;
                dw_ctrl_q[k]   <= reg_reset;
                rw_mask_q[k]   <= reg_reset;
                rw_value_q[k]  <= reg_reset;
                rw_ctrl_q[k]   <= reg_reset;
            end
        end else if (reg_write) begin
            if (sel_ib_a) ib_addr_q[idx]   <= reg_wdata;                                 // [RULE2]
            if (sel_ib_c) ib_ctrl_q[idx]   <= reg_wdata & instr_ctrl_mask;               // [RULE2]
            if (sel_dw_1) dw_first_q[idx]  <= reg_wdata;                                 // [RULE6]
            if (sel_dw_2) dw_second_q[idx] <= reg_wdata;                                 // [RULE6]
            if (sel_dw_c) dw_ctrl_q[idx]   <= reg_wdata & data_ctrl_mask;
            if (sel_rw_m) rw_mask_q[idx]   <= reg_wdata;                                 // [RULE10]
            if (sel_rw_v) rw_value_q[idx]  <= reg_wdata;                                 // [RULE10]
            if (sel_rw_c) rw_ctrl_q[idx]   <= reg_wdata & res_ctrl_mask;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Cause capture; a hit overrides a debugger write in the same cycle

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            cause_q  <= cause_none;
            number_q <= 2'h0;
            core_q   <= 8'h00;
        end else if (any_hit) begin
            cause_q  <= hit_cause;                                                       // [RULE13]
            number_q <= hit_number;                                                      // [RULE14]
            core_q   <= {5'h00, hit_core};
        end else if (reg_write && sel_cause) begin
            cause_q  <= reg_wdata[2:0];
            number_q <= reg_wdata[cause_number_lsb +: 2];
            core_q   <= reg_wdata[cause_core_lsb +: 8];
        end
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            data_q <= reg_reset;
        end else if (data_load) begin
            data_q <= hit_data;                                                          // [RULE15]
        end else if (reg_write && sel_data) begin
            data_q <= reg_wdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Interrupt, event pulse and read port

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            status_q <= 3'h0;
            mask_q   <= 3'h0;
        end else begin
            status_q <= status_d;
            if (reg_write && sel_mask) mask_q <= reg_wdata[2:0];
        end
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            event_q <= '0;
        end else begin
            event_q <= '{pulse: any_hit, cause: hit_cause, number: hit_number, core: hit_core}; // [RULE1]
        end
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            rdata_q <= 32'h0000_0000;
        end else begin
            rdata_q <= reg_read ? read_mux : 32'h0000_0000;
        end
    end

    assign debug_event = event_q;
    assign irq         = |(status_q & mask_q);
    assign reg_rdata   = rdata_q;

endmodule

// >>> src/bp_watch_pkg.sv
package bp_watch_pkg;

    localparam int          unit_count          = 4;
    localparam int          core_count          = 8;

    // Register numbers: first of each group of four, then the four single registers
    localparam logic [7:0]  instr_break_address_base     = 8'h30;
    localparam logic [7:0]  instr_break_control_base     = 8'h40;
    localparam logic [7:0]  data_watch_first_bound_base  = 8'h50;
    localparam logic [7:0]  data_watch_second_bound_base = 8'h60;
    localparam logic [7:0]  data_watch_control_base      = 8'h70;
    localparam logic [7:0]  resource_watch_mask_base     = 8'h80;
    localparam logic [7:0]  resource_watch_value_base    = 8'h90;
    localparam logic [7:0]  resource_watch_control_base  = 8'h9c;
    localparam logic [7:0]  debug_cause_reg              = 8'h15;
    localparam logic [7:0]  debug_data_reg               = 8'h16;
    localparam logic [7:0]  irq_status_reg               = 8'ha0;
    localparam logic [7:0]  irq_mask_reg                 = 8'ha4;

    // Control fields
    localparam int          ctrl_enable_bit     = 0;
    localparam int          ctrl_invert_bit     = 1;
    localparam int          ctrl_load_bit       = 2;
    localparam int          ctrl_core_lsb       = 16;
    localparam logic [31:0] instr_ctrl_mask     = 32'h00ff_0003;
    localparam logic [31:0] data_ctrl_mask      = 32'h00ff_0007;
    localparam logic [31:0] res_ctrl_mask       = 32'h00ff_0003;
    localparam logic [31:0] reg_reset           = 32'h0000_0000;

    // Cause register fields
    localparam int          cause_number_lsb    = 16;
    localparam int          cause_core_lsb      = 8;
    localparam logic [2:0]  cause_none          = 3'h0;
    localparam logic [2:0]  cause_instr         = 3'h3;
    localparam logic [2:0]  cause_data          = 3'h4;
    localparam logic [2:0]  cause_resource      = 3'h5;

    // Status and mask bits
    localparam int          irq_instr_bit       = 0;
    localparam int          irq_data_bit        = 1;
    localparam int          irq_res_bit         = 2;

    typedef struct packed {
        logic        valid;
        logic [2:0]  core;
        logic [31:0] program_counter;
    } fetch_req_t;

    typedef struct packed {
        logic        valid;
        logic        store;
        logic [2:0]  core;
        logic [31:0] addr;
    } mem_req_t;

    typedef struct packed {
        logic        valid;
        logic [2:0]  core;
        logic [31:0] res_id;
    } res_req_t;

    typedef struct packed {
        logic        pulse;
        logic [2:0]  cause;
        logic [1:0]  number;
        logic [2:0]  core;
    } debug_event_t;

endpackage

// >>> verification/core_model.sv
module core_model
    import bp_watch_pkg::*;
(
    input  wire logic  clock,
    output fetch_req_t fetch_req,
    output mem_req_t   mem_req,
    output res_req_t   res_req
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        fetch_req = '0;
        mem_req   = '0;
        res_req   = '0;
    end

    // One request for one cycle; kind 0 fetch, 1 memory, 2 resource
    task automatic issue(input int kind, input logic st, input logic [2:0] c, input logic [31:0] v);
        @(posedge clock);
        case (kind)
            0: fetch_req <= '{1'b1, c, v};
            1: mem_req <= '{1'b1, st, c, v};
            default: res_req <= '{1'b1, c, v};
        endcase
        @(posedge clock);
        // Payload inverted on release so a stale value never hits by luck
        fetch_req <= {1'b0, ~fetch_req[34:0]};
        mem_req <= {1'b0, ~mem_req[35:0]};
        res_req <= {1'b0, ~res_req[34:0]};
    endtask
endmodule

// >>> verification/breakpoint_watchpoint_unit_props.sv
module breakpoint_watchpoint_unit_props
    import bp_watch_pkg::*;
(
    input wire logic         clock,
    input wire logic         reset,
    input wire logic         reg_write,
    input wire logic         reg_read,
    input wire logic [31:0]  reg_rdata,
    input wire fetch_req_t   fetch_req,
    input wire mem_req_t     mem_req,
    input wire res_req_t     res_req,
    input wire debug_event_t debug_event,
    input wire logic         irq
);
    default clocking @(posedge clock); endclocking
    default disable iff (reset);

    ////////////////////////////////////////////////////////////////
    rdata_idle_a: assert property (!$past(reg_read) |-> reg_rdata == 32'h0)
        else $error("read data not zero outside read answer");
    cause_code_a: assert property (debug_event.pulse |-> debug_event.cause inside {3'h3, 3'h4, 3'h5})
        else $error("bad cause code");
    instr_source_a: assert property (debug_event.pulse && debug_event.cause == cause_instr |->
        $past(fetch_req.valid) && debug_event.core == $past(fetch_req.core)) else $error("instr hit without fetch");
    data_source_a: assert property (debug_event.pulse && debug_event.cause == cause_data |->
        $past(mem_req.valid) && debug_event.core == $past(mem_req.core)) else $error("data hit without access");
    res_source_a: assert property (debug_event.pulse && debug_event.cause == cause_resource |->
        $past(res_req.valid) && debug_event.core == $past(res_req.core)) else $error("resource hit without id");
    hit_cause_a: assert property (debug_event.pulse |-> $past(fetch_req.valid || mem_req.valid || res_req.valid))
        else $error("hit with no request");
    irq_rise_a: assert property ($rose(irq) |-> debug_event.pulse || $past(reg_write))
        else $error("irq rose without cause");
    irq_fall_a: assert property ($fell(irq) |-> $past(reg_write))
        else $error("irq fell without write");

    cover property (debug_event.pulse && debug_event.cause == cause_instr);
    cover property (debug_event.pulse && debug_event.cause == cause_data);
    cover property (debug_event.pulse && debug_event.cause == cause_resource);
endmodule

bind breakpoint_watchpoint_unit breakpoint_watchpoint_unit_props props (.clock, .reset, .reg_write, .reg_read,
    .reg_rdata, .fetch_req, .mem_req, .res_req, .debug_event, .irq);

// >>> verification/breakpoint_watchpoint_unit_tb.sv
module breakpoint_watchpoint_unit_tb
    import bp_watch_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic         clock, reset, reg_write, reg_read, irq;
    logic [7:0]   reg_addr;
    logic [31:0]  reg_wdata, reg_rdata;
    fetch_req_t   fetch_req;
    mem_req_t     mem_req;
    res_req_t     res_req;
    debug_event_t debug_event;
    int           n_errors, checks;
    // Data watch table: control, store, address, expected hit
    logic [31:0]  dctl [8] = '{32'h40001, 32'h40001, 32'h40001, 32'h40001, 32'h40005, 32'h40007, 32'h40007, 32'h40007};
    logic         dst [8]  = '{1, 1, 1, 0, 0, 1, 1, 0};
    logic [31:0]  dad [8]  = '{32'h1000, 32'h1fff, 32'h2000, 32'h1000, 32'h1000, 32'h1000, 32'h1fff, 32'h0fff};
    logic         dex [8]  = '{1, 1, 0, 0, 1, 0, 0, 1};

    breakpoint_watchpoint_unit dut (.clock, .reset, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata,
        .fetch_req, .mem_req, .res_req, .debug_event, .irq);
    core_model core (.clock, .fetch_req, .mem_req, .res_req);

    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end

    ////////////////////////////////////////////////////////////////
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clock);
        reg_write <= 1'b0;
        #1;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clock);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clock);
        reg_read <= 1'b0;
        #1 chk($sformatf("reg %h", a), exp, reg_rdata);
    endtask

    // Cause none means no hit expected
    task automatic hit(input int k, input logic st, input logic [2:0] c, input logic [31:0] v,
                       input logic [2:0] cause, input logic [1:0] num);
        core.issue(k, st, c, v);
        #1 chk("pulse", 32'(cause != cause_none), 32'(debug_event.pulse));
        if (cause != cause_none) begin
            chk("cause", 32'(cause), 32'(debug_event.cause));
            chk("number", 32'(num), 32'(debug_event.number));
            chk("core", 32'(c), 32'(debug_event.core));
        end
    endtask

    task automatic close_out;
        $display("checks %0d errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////
    initial begin
        reset = 1'b1;
        reg_addr = 8'h00;
        reg_wdata = 32'h0;
        reg_write = 1'b0;
        reg_read = 1'b0;
        repeat (20) @(posedge clock);
        reset <= 1'b0;
        rd(8'h40, reg_reset);
        rd(8'h73, reg_reset);
        wr(8'h41, 32'hffff_ffff);
        rd(8'h41, instr_ctrl_mask);
        wr(8'h72, 32'hffff_ffff);
        rd(8'h72, data_ctrl_mask);
        wr(8'h72, 32'h0);
        wr(8'h05, 32'hffff_ffff);
        rd(8'h05, 32'h0);
        for (int i = 0; i < 4; i++) begin
            wr(instr_break_address_base + 8'(i), 32'h100 + i);
            wr(instr_break_control_base + 8'(i), 32'h0001_0001);
        end
        for (int i = 0; i < 4; i++) hit(0, 0, 0, 32'h100 + i, cause_instr, 2'(i));
        hit(0, 0, 1, 32'h102, cause_none, 0);
        wr(8'h40, 32'h0001_0003);
        hit(0, 0, 0, 32'h102, cause_instr, 0);
        hit(0, 0, 0, 32'h100, cause_none, 0);
        for (int i = 0; i < 4; i++) wr(instr_break_control_base + 8'(i), 32'h0001_0000);
        hit(0, 0, 0, 32'h101, cause_none, 0);
        wr(8'h51, 32'h1000);
        wr(8'h61, 32'h1fff);
        for (int i = 0; i < 8; i++) begin
            wr(8'h71, dctl[i]);
            hit(1, dst[i], 2, dad[i], dex[i] ? cause_data : cause_none, 1);
        end
        rd(debug_data_reg, 32'h0fff);
        wr(8'h83, 32'hff00);
        wr(8'h93, 32'h1200);
        wr(8'h9f, 32'h0080_0001);
        hit(2, 0, 7, 32'h1234, cause_resource, 3);
        hit(2, 0, 7, 32'h1334, cause_none, 0);
        rd(debug_cause_reg, 32'h0003_0705);
        rd(debug_data_reg, 32'h1234);
        wr(8'h9f, 32'h0080_0003);
        hit(2, 0, 7, 32'h1334, cause_resource, 3);
        hit(2, 0, 7, 32'h12ff, cause_none, 0);
        rd(irq_status_reg, 32'h7);
        chk("irq", 32'h0, 32'(irq));
        wr(irq_mask_reg, 32'h2);
        chk("irq", 32'h1, 32'(irq));
        wr(irq_status_reg, 32'h5);
        rd(irq_status_reg, 32'h2);
        wr(irq_status_reg, 32'h2);
        chk("irq", 32'h0, 32'(irq));
        wr(irq_mask_reg, 32'h4);
        hit(2, 0, 7, 32'h1334, cause_resource, 3);
        chk("irq", 32'h1, 32'(irq));
        close_out();
    end

    initial begin
        repeat (20000) @(posedge clock);
        n_errors++;
        close_out();
    end
endmodule
